// ===== reset_and_clock_output_control.sv
`timescale 1ns/100ps
`default_nettype none

module reset_and_clock_output_control
	import reset_clock_pkg::*;
(
	// master clock and pin reset
	input wire logic clk,
	input wire logic rst_b,
	// straps
	input wire logic boot_width_strap,
	input wire logic tristate_strap_low,
	// watchdog reset request, same clock
	input wire logic wdt_reset_req,
	// parallel I/O controller claim on the clock pin
	input wire logic pio_clock_pin_claim,
	// memory die pins
	input wire logic memory_die_select_low,
	input wire logic memory_die_reset_low,
	input wire logic write_protect_low,
	input wire logic die_op_busy,
	// processor and peripherals
	output logic sys_rst_low,
	output logic core_run,
	output logic fetch_from_zero,
	output logic periph_force_input,
	output logic boot_8bit,
	output logic tristate_mode,
	// clock output pin
	output logic clock_output_pin,
	output logic clock_output_oe,
	// memory die
	output die_ctrl_s die_ctrl,
	output logic memory_die_busy_low_o,
	output logic memory_die_busy_low_oe
);

	//----------------------------------------------------------------
	// pin front end
	//----------------------------------------------------------------
	strap_s strap;
	die_ctrl_s die;

	die_pin_front u_front (
		.clk(clk),
		.boot_width_strap(boot_width_strap),
		.tristate_strap_low(tristate_strap_low),
		.memory_die_select_low(memory_die_select_low),
		.memory_die_reset_low(memory_die_reset_low),
		.write_protect_low(write_protect_low),
		.die_op_busy(die_op_busy),
		.strap(strap),
		.die(die)
	);

	//----------------------------------------------------------------
	// sequencer
	//----------------------------------------------------------------
	seq_s s_q;
	seq_s s_d;
	logic release_ok;
	logic pin_rise;

	// next state
	always_comb
	begin
		s_d = s_q;
		// pin release enters through two stages
		s_d.pin_s1 = 1'b1;
		s_d.pin_s2 = s_q.pin_s1;
		s_d.pin_prev = s_q.pin_s2;
		// watchdog pulls the internal reset, release through two stages
		s_d.wd_s1 = ~wdt_reset_req;
		s_d.wd_s2 = s_q.wd_s1 & ~wdt_reset_req;
		release_ok = s_q.pin_s2 & s_q.wd_s2;
		pin_rise = s_q.pin_s2 & ~s_q.pin_prev;
		// straps only on a pin release; a watchdog cycle leaves them alone
		if (pin_rise)
		begin
			s_d.boot_8bit = strap.width_all_high;
			s_d.tristate = strap.tri_all_low;
		end
		s_d.fetch_zero = 1'b0;
		case (s_q.phase)
			PH_RESET:
			begin
				s_d.fetch_cnt = FETCH_CNT_RST;
				if (release_ok)
				begin
					s_d.phase = PH_WAIT;
				end
			end
			PH_WAIT:
			begin
				// counts from the pin edge, two clocks already spent syncing
				if (s_q.fetch_cnt == FETCH_LAST)
				begin
					s_d.phase = PH_RUN;
					s_d.fetch_zero = 1'b1;
				end
				else
				begin
					s_d.fetch_cnt = s_q.fetch_cnt + 7'h01;
				end
			end
			PH_RUN:
			begin
				s_d.fetch_cnt = s_q.fetch_cnt;
			end
			default:
			begin
				s_d.phase = PH_RESET;
			end
		endcase
		// a watchdog reset restarts the whole release sequence
		if (!release_ok)
		begin
			s_d.phase = PH_RESET;
			s_d.fetch_cnt = FETCH_CNT_RST;
			s_d.fetch_zero = 1'b0;
		end
		s_d.sys_rst_low = release_ok;
		s_d.core_run = (s_d.phase == PH_RUN);
		// tri-state folded in ahead of the flop so the pad control is registered
		s_d.force_input = ~release_ok | s_d.tristate;
		// the clock pin stays a clock image until software hands it over
		s_d.clk_pin_gpio = release_ok & pio_clock_pin_claim;
		s_d.clk_pin_oe = ~s_d.tristate & ~s_d.clk_pin_gpio;
	end

	// register; pin reset acts at once, no clock needed
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			s_q.pin_s1 <= 1'b0;
			s_q.pin_s2 <= 1'b0;
			s_q.pin_prev <= 1'b0;
			s_q.wd_s1 <= 1'b0;
			s_q.wd_s2 <= 1'b0;
			s_q.phase <= PH_RESET;
			s_q.fetch_cnt <= FETCH_CNT_RST;
			s_q.boot_8bit <= BOOT_8BIT_RST;
			s_q.tristate <= TRISTATE_RST;
			s_q.sys_rst_low <= 1'b0;
			s_q.core_run <= 1'b0;
			s_q.fetch_zero <= 1'b0;
			s_q.force_input <= 1'b1;
			s_q.clk_pin_gpio <= 1'b0;
			s_q.clk_pin_oe <= 1'b1;
		end
		else
		begin
			s_q <= s_d;
		end
	end

	//----------------------------------------------------------------
	// outputs
	//----------------------------------------------------------------
	assign sys_rst_low = s_q.sys_rst_low;
	assign core_run = s_q.core_run;
	assign fetch_from_zero = s_q.fetch_zero;
	assign periph_force_input = s_q.force_input;
	assign boot_8bit = s_q.boot_8bit;
	assign tristate_mode = s_q.tristate;
	// the clock image cannot come from a flop; the pad sees clk gated by a held select
	assign clock_output_pin = clk & ~s_q.clk_pin_gpio;
	assign clock_output_oe = s_q.clk_pin_oe;
	assign die_ctrl = die;
	// open drain: only ever pulls low
	assign memory_die_busy_low_o = 1'b0;
	assign memory_die_busy_low_oe = die.busy_oe;

endmodule

`default_nettype wire

// ===== reset_clock_pkg.sv
//--------------------------------------------------------------------
// What this block does
// - pin reset low puts the device in reset at once, no clock needed.
// - leaving reset follows the master clock, pin release synchronised first.
// - first processor fetch happens exactly 80 clocks after pin reset rises.
// - any reset restores peripheral defaults and makes next fetch start at zero.
// - processor registers other than program counter have no defined reset value.
// - watchdog reset acts on registers and processor like the pin reset.
// - watchdog reset keeps latched boot width and tri-state mode, no strap sampling.
// - pin reset wins over a simultaneous watchdog reset, with its sampling and timing.
// - clock output pin carries the master clock during and after reset.
// - after reset every peripheral I/O line is an input.
// - memory die is enabled only while its select input is low.
// - memory die pulls open-drain busy low during an operation, else releases.
// - memory die reset low restores standard mode, independent of processor reset.
// - memory die refuses program and erase while write protect is low.
// - boot width strap is taken from the last ten clocks before pin release.
// - latched boot width 1 means 8-bit boot memory, 0 means 16-bit.
// - tri-state strap low for the last ten clocks disables the clock pin driver and forces peripheral lines to input.
// - memory die reset low halts its operation and floats its outputs.
//--------------------------------------------------------------------
package reset_clock_pkg;

	// cycle counts at the 50 MHz master clock
	localparam int CLK_PERIOD_NS = 20;
	localparam int SYNC_STAGES = 2;
	localparam int CLOCK_VALID_CYCLES = 10;
	localparam int STRAP_WINDOW = 10;
	localparam int FIRST_FETCH_CYCLES = 80;
	// counter value one clock before the run flag rises
	// two edges go to the synchroniser, one to the phase change, one to the run flop
	localparam logic [6:0] FETCH_LAST = 7'(FIRST_FETCH_CYCLES - SYNC_STAGES - 2);

	// values after a pin reset, before the straps are taken
	localparam logic BOOT_8BIT_RST = 1'b0;
	localparam logic TRISTATE_RST = 1'b0;
	localparam logic [6:0] FETCH_CNT_RST = 7'h00;

	// sequencer phases
	typedef enum logic [1:0] {PH_RESET, PH_WAIT, PH_RUN} phase_e;

	// memory die pin outputs
	typedef struct packed {
		logic enable;
		logic halt;
		logic out_hiz;
		logic prog_allowed;
		logic busy_oe;
	} die_ctrl_s;

	// strap window summary
	typedef struct packed {
		logic width_all_high;
		logic tri_all_low;
	} strap_s;

	// front-end state: synchronisers and strap history
	typedef struct packed {
		logic [SYNC_STAGES-1:0] width_sync;
		logic [SYNC_STAGES-1:0] tri_sync;
		logic [SYNC_STAGES-1:0] sel_sync;
		logic [SYNC_STAGES-1:0] drst_sync;
		logic [SYNC_STAGES-1:0] wp_sync;
		logic [STRAP_WINDOW-1:0] width_hist;
		logic [STRAP_WINDOW-1:0] tri_hist;
		strap_s strap;
		die_ctrl_s die;
	} front_s;

	// sequencer state
	typedef struct packed {
		logic pin_s1;
		logic pin_s2;
		logic pin_prev;
		logic wd_s1;
		logic wd_s2;
		phase_e phase;
		logic [6:0] fetch_cnt;
		logic boot_8bit;
		logic tristate;
		logic sys_rst_low;
		logic core_run;
		logic fetch_zero;
		logic force_input;
		logic clk_pin_gpio;
		logic clk_pin_oe;
	} seq_s;

endpackage

// ===== die_pin_front.sv
`timescale 1ns/100ps
`default_nettype none

module die_pin_front
	import reset_clock_pkg::*;
(
	// clock
	input wire logic clk,
	// strap pins, asynchronous
	input wire logic boot_width_strap,
	input wire logic tristate_strap_low,
	// memory die pins, asynchronous
	input wire logic memory_die_select_low,
	input wire logic memory_die_reset_low,
	input wire logic write_protect_low,
	// memory die core status
	input wire logic die_op_busy,
	// results
	output strap_s strap,
	output die_ctrl_s die
);

	//----------------------------------------------------------------
	// state
	//----------------------------------------------------------------
	// no reset here on purpose: straps must be watched while the pin
	// reset is low, and the die must ignore the processor reset
	front_s r_q;
	front_s r_d;

	// next state
	always_comb
	begin
		r_d = r_q;
		r_d.width_sync = {r_q.width_sync[0], boot_width_strap};
		r_d.tri_sync = {r_q.tri_sync[0], tristate_strap_low};
		r_d.sel_sync = {r_q.sel_sync[0], memory_die_select_low};
		r_d.drst_sync = {r_q.drst_sync[0], memory_die_reset_low};
		r_d.wp_sync = {r_q.wp_sync[0], write_protect_low};
		// window of the last samples, aligned with the reset synchroniser
		r_d.width_hist = {r_q.width_hist[STRAP_WINDOW-2:0], r_q.width_sync[1]};
		r_d.tri_hist = {r_q.tri_hist[STRAP_WINDOW-2:0], r_q.tri_sync[1]};
		r_d.strap.width_all_high = &r_d.width_hist;
		r_d.strap.tri_all_low = ~|r_d.tri_hist;
		r_d.die.enable = ~r_q.sel_sync[1] & r_q.drst_sync[1];
		r_d.die.halt = ~r_q.drst_sync[1];
		r_d.die.out_hiz = ~r_q.drst_sync[1] | r_q.sel_sync[1];
		r_d.die.prog_allowed = r_q.wp_sync[1] & r_q.drst_sync[1];
		// busy only while an operation runs and the die is not held in reset
		r_d.die.busy_oe = die_op_busy & r_q.drst_sync[1];
	end

	// register
	always_ff @(posedge clk)
	begin
		r_q <= r_d;
	end

	assign strap = r_q.strap;
	assign die = r_q.die;

endmodule

`default_nettype wire

// ===== rcoc_checker.sv
`timescale 1ns/100ps
`default_nettype none

module rcoc_checker
	import reset_clock_pkg::*;
(
	// clock, resets and requests
	input wire logic clk,
	input wire logic rst_b,
	input wire logic wdt_reset_req,
	input wire logic pio_clock_pin_claim,
	input wire logic memory_die_reset_low,
	// watched outputs
	input wire logic sys_rst_low,
	input wire logic core_run,
	input wire logic periph_force_input,
	input wire logic boot_8bit,
	input wire logic tristate_mode,
	input wire logic clock_output_oe,
	input wire die_ctrl_s die_ctrl,
	input wire logic memory_die_busy_low_oe
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_b);
	// pin reset checks must stay live while the pin is low
	a_pin_holds_core: assert property (disable iff (1'b0) !rst_b |-> !sys_rst_low && !core_run)
		else $error("core live in pin reset");
	a_release_sync: assert property ($rose(rst_b) |-> !sys_rst_low [*3] ##1 sys_rst_low)
		else $error("release not synced");
	a_first_fetch: assert property ($rose(rst_b) |-> ##79 !core_run ##1 core_run)
		else $error("first fetch off count");
	a_wdt_resets: assert property (wdt_reset_req |=> ##1 (!sys_rst_low && !core_run))
		else $error("watchdog did not reset");
	a_wdt_keeps_modes: assert property (wdt_reset_req |=> $stable(boot_8bit) && $stable(tristate_mode))
		else $error("watchdog moved modes");
	a_clock_pin_on: assert property (disable iff (1'b0) !rst_b && !pio_clock_pin_claim |-> clock_output_oe)
		else $error("clock pin off in reset");
	a_tristate_quiet: assert property (tristate_mode [*2] |-> !clock_output_oe && periph_force_input)
		else $error("driver on in tri-state");
	a_die_reset_hiz: assert property ($fell(memory_die_reset_low) |-> ##[2:4]
		(die_ctrl.halt && die_ctrl.out_hiz && !memory_die_busy_low_oe))
		else $error("die not halted");
endmodule

bind reset_and_clock_output_control rcoc_checker i_chk (.*);

`default_nettype wire

// ===== board_model.sv
`timescale 1ns/100ps
`default_nettype none

module board_model
(
	// bench commands
	input wire logic clk,
	input wire logic press,
	input wire logic wl,
	input wire logic tl,
	// board pins
	// starts high so the first falling edge gives the design a real reset edge
	output logic rst_b = 1'b1,
	output logic bws = 1'b1,
	output logic tsl = 1'b1
);
	logic [3:0] low_cnt = 4'h0;
	// twelve clocks low before release keeps the clock valid and fills the strap window
	always @(negedge clk)
	begin
		bws <= wl;
		tsl <= tl;
		low_cnt <= press ? 4'h0 : low_cnt + {3'h0, !rst_b && low_cnt != 4'hc};
		rst_b <= !press && (rst_b || low_cnt == 4'hc);
	end
endmodule

`default_nettype wire

// ===== reset_and_clock_output_control_bench.sv
`timescale 1ns/100ps
`default_nettype none

module reset_and_clock_output_control_bench;
	import reset_clock_pkg::*;
	logic clk, press = 1'b1, wl = 1'b1, tl = 1'b1, wdt = 1'b0, claim = 1'b0;
	logic sel = 1'b1, drst = 1'b1, wp = 1'b1, busy = 1'b0;
	logic rst_b, bws, tsl, srl, run, f0, fin, b8, tm, cop, coe, bo, boe;
	die_ctrl_s die;
	int fails = 0;
	int tests_run = 0;
	int cyc = 0;
	// master clock
	initial
	begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	board_model i_board (.clk(clk), .press(press), .wl(wl), .tl(tl), .rst_b(rst_b), .bws(bws),
		.tsl(tsl));
	reset_and_clock_output_control i_dut (.clk(clk), .rst_b(rst_b), .boot_width_strap(bws),
		.tristate_strap_low(tsl), .wdt_reset_req(wdt), .pio_clock_pin_claim(claim),
		.memory_die_select_low(sel), .memory_die_reset_low(drst), .write_protect_low(wp),
		.die_op_busy(busy), .sys_rst_low(srl), .core_run(run), .fetch_from_zero(f0),
		.periph_force_input(fin), .boot_8bit(b8), .tristate_mode(tm), .clock_output_pin(cop),
		.clock_output_oe(coe), .die_ctrl(die), .memory_die_busy_low_o(bo),
		.memory_die_busy_low_oe(boe));
	task automatic chk(input string what, input logic seen, input logic exp);
		tests_run++;
		if (seen !== exp)
		begin
			fails++;
			$display("mismatch %s expected %b seen %b", what, exp, seen);
		end
	endtask
	task automatic print_verdict(input int extra);
		fails += extra;
		if (fails == 0 && tests_run > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	// a hang counts as a mismatch
	always @(posedge clk)
	begin
		cyc++;
		if (cyc > 3000)
			print_verdict(1);
	end
	// falling edges until the core may fetch, bounded
	task automatic wait_run(output int n);
		n = 0;
		while (run !== 1'b1 && n < 200)
		begin
			@(negedge clk);
			n++;
		end
	endtask
	// pin reset with given straps, watchdog optionally raised at the same time
	task automatic pin_reset(input logic w, input logic t, input logic wd);
		int n;
		wl <= w;
		tl <= t;
		wdt = wd;
		press <= 1'b1;
		repeat (5) @(negedge clk);
		chk("fin", fin, 1'b1);
		#15 chk("cop", cop, 1'b1);
		@(negedge clk);
		wdt = 1'b0;
		press <= 1'b0;
		wait (rst_b === 1'b1);
		wait_run(n);
		chk("delay", n == FIRST_FETCH_CYCLES, 1'b1);
		chk("f0", f0, 1'b1);
		chk("b8", b8, w);
		chk("tm", tm, !t);
		chk("coe", coe, t);
		@(negedge clk);
		chk("f0", f0, 1'b0);
	endtask
	// watchdog pulse with straps flipped; latched modes must hold
	task automatic wdt_reset;
		int n;
		logic b;
		logic t;
		b = b8;
		t = tm;
		wl <= !b;
		tl <= t;
		wdt = 1'b1;
		repeat (2) @(negedge clk);
		chk("fin", fin, 1'b1);
		wdt = 1'b0;
		wait_run(n);
		chk("wdelay", n > 76 && n < 90, 1'b1);
		chk("b8", b8, b);
		chk("tm", tm, t);
	endtask
	// memory die pins with the core running; clock pin claimed meanwhile
	task automatic die_pins;
		sel = 1'b0;
		busy = 1'b1;
		claim = 1'b1;
		repeat (4) @(negedge clk);
		chk("en", die.enable, 1'b1);
		chk("boe", boe, 1'b1);
		chk("prog", die.prog_allowed, 1'b1);
		chk("coe", coe, 1'b0);
		#15 chk("cop", cop, 1'b0);
		@(negedge clk);
		sel = 1'b1;
		wp = 1'b0;
		claim = 1'b0;
		repeat (4) @(negedge clk);
		chk("en", die.enable, 1'b0);
		chk("prog", die.prog_allowed, 1'b0);
		drst = 1'b0;
		repeat (4) @(negedge clk);
		chk("boe", boe, 1'b0);
		chk("halt", die.halt, 1'b1);
		chk("hiz", die.out_hiz, 1'b1);
		chk("run", run, 1'b1);
		drst = 1'b1;
		repeat (4) @(negedge clk);
		chk("bo", bo, 1'b0);
	endtask
	initial
	begin
		repeat (5) @(negedge clk);
		pin_reset(1'b1, 1'b1, 1'b0);
		die_pins;
		wdt_reset;
		pin_reset(1'b0, 1'b0, 1'b1);
		wdt_reset;
		print_verdict(0);
	end
endmodule

`default_nettype wire
